/* File: rtl/tsc_consts.svh */
// Constants of the tile status and configuration register bank.
// Assumes it is included once per file by its bare name.
`ifndef TSC_CONSTS_SVH
`define TSC_CONSTS_SVH

`define TSC_REG_RAM_BASE 8'h00
`define TSC_REG_VEC_BASE 8'h01
`define TSC_REG_TILE_CTRL 8'h02
`define TSC_REG_BOOT_STATE 8'h03
`define TSC_REG_SECURITY 8'h05
`define TSC_REG_DBG_THREAD 8'h13
`define TSC_REG_DBG_REGNUM 8'h14
`define TSC_REG_DBG_CAUSE 8'h15

`define TSC_RES_TYPE_PS 8'h0B
`define TSC_NO_REPLY_LOW 8'hFF
`define TSC_CFG_DEST_LOW 16'hC20C

`define TSC_RAM_BASE_RESET 32'h00040000
`define TSC_RAM_BASE_MASK 32'hFFFFFFFC
`define TSC_VEC_BASE_MASK 32'hFFFC0000
`define TSC_TILE_CTRL_MASK 32'h03FFFF30
`define TSC_SECURITY_MASK 32'h80005FB1
`define TSC_DBG_THREAD_MASK 32'h000000FF
`define TSC_DBG_REGNUM_MASK 32'h0000001F
`define TSC_DBG_CAUSE_MASK 32'h0003FF07

`define TSC_SEC_LOCK_BIT 31
`define TSC_CTRL_DIV_EN_BIT 4
`define TSC_CTRL_DYN_BIT 5
`define TSC_CTRL_RGMII_EN_BIT 8
`define TSC_CTRL_TXDIV_LSB 9
`define TSC_CTRL_TXDLY_LSB 18

`define TSC_CAUSE_HOST 3'h1
`define TSC_CAUSE_DEBUG_CALL_INSTR 3'h2
`define TSC_CAUSE_IBRK 3'h3
`define TSC_CAUSE_DWATCH 3'h4
`define TSC_CAUSE_RWATCH 3'h5

`define TSC_MSG_RD 8'h01
`define TSC_MSG_WR 8'h02

`endif

/* File: rtl/tsc_pkg.sv */
// Types shared by the tile status and configuration register bank.
// Assumes the consts header holds all numeric constants.
package tsc_pkg;
  // Local core access from status-register instructions.
  typedef struct packed {
    logic valid;
    logic write;
    logic [15:0] res_id;
    logic [31:0] wdata;
  } tsc_ps_req_type;

  // One byte of an interconnect channel message, in or out.
  typedef struct packed {
    logic valid;
    logic last;
    logic [7:0] data;
  } tsc_byte_type;

  // Debug interrupt report from the core.
  typedef struct packed {
    logic valid;
    logic [2:0] cause;
    logic [7:0] thread;
    logic [3:0] unit_hits;
  } tsc_dbg_evt_type;

  typedef enum logic [1:0] {TSC_ACC_NONE, TSC_ACC_READ, TSC_ACC_WRITE} tsc_acc_type;
endpackage

/* File: rtl/tsc_lowest_hit.sv */
// Picks the lowest numbered unit among simultaneous breakpoint hits.
// Assumes hits are a plain one-cycle vector from the core.
`timescale 1ns/1ps
`default_nettype none
module tsc_lowest_hit
(
  input wire logic [3:0] hits,
  output logic [1:0] index
);
  // Priority from unit 0 upward so the lowest number wins.
  assign index = hits[0] ? 2'h0 : hits[1] ? 2'h1 : hits[2] ? 2'h2 : hits[3] ? 2'h3 : 2'h0;
endmodule
`default_nettype wire

/* File: rtl/tsc_msg_rx.sv */
// Collects an interconnect access message byte by byte.
// Assumes message: cmd, 3 return bytes, reg number, then 4 data bytes on writes.
`timescale 1ns/1ps
`default_nettype none
`include "tsc_consts.svh"
module tsc_msg_rx
  import tsc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire tsc_pkg::tsc_byte_type rx_in,
  output logic done,
  output logic is_write,
  output logic [23:0] ret_dest,
  output logic [7:0] reg_num,
  output logic [31:0] wdata
);
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic [71:0] shift_r;
  logic [71:0] shift_nxt;
  logic done_r;
  logic long_r;
  logic long_nxt;

  // Bytes arrive most significant first, so each new byte shifts in at the bottom.
  assign shift_nxt = rx_in.valid ? {shift_r[63:0], rx_in.data} : shift_r; // R3
  assign cnt_nxt = (rx_in.valid && rx_in.last) ? 4'h0 : rx_in.valid ? cnt_r + 4'h1 : cnt_r;
  // The length is latched on the last byte, because the byte counter clears to zero on that same byte.
  assign long_nxt = (rx_in.valid && rx_in.last) ? (cnt_r > 4'h4) : long_r;

  // A message ends on its last byte; short writes are accepted as read length.
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      cnt_r <= 4'h0;
      shift_r <= 72'h0;
      done_r <= 1'b0;
      long_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      shift_r <= shift_nxt;
      done_r <= rx_in.valid && rx_in.last;
      long_r <= long_nxt;
    end
  end

  // Latched length and command byte together decide where the fields sit in the shifted frame.
  assign is_write = long_r && (shift_r[71:64] == `TSC_MSG_WR);
  assign done = done_r;
  assign ret_dest = is_write ? shift_r[63:40] : shift_r[31:8]; // R1
  assign reg_num = is_write ? shift_r[39:32] : shift_r[7:0];
  assign wdata = shift_r[31:0];
endmodule
`default_nettype wire

/* File: rtl/tsc_regs.sv */
// Tile status and configuration register bank with local and interconnect access.
// Assumes one clock, synchronous reset, and a core that reports debug events.
//
// Contract
// R1: Requests carry 24-bit response channel-end.
// R2: Return low byte all ones suppresses reply.
// R3: Multi-byte fields travel most significant first.
// R4: Local resource id is register<<8 OR 0x0B.
// R5: Requester targets tile id with C20C.
// R6: RAM base resets 0x00040000, bits 1:0 read-only.
// R7: Vector address joins base top and event vector.
// R8: Control 25:18 holds transmit data delay.
// R9: Control 17:9 sets transmit clock divider.
// R10: Control bit 8 enables interface ports.
// R11: Bits 4,5 enable and make dynamic divider.
// R12: Boot status read-only, reports boot straps.
// R13: Security register copies one-time-programmable word.
// R14: Security bit 31 locks further writes.
// R15: Security debug, sector lock, redundancy bits.
// R16: Security boot override, JTAG blocking bits.
// R17: Debug operands hold thread and register.
// R18: Debug cause bits 2:0 encode source.
// R19: Cause bits 17:16 lowest firing unit.
// R20: Cause bits 15:8 thread, zero for host.
// R21: Divider value comes from separate register.
// R22: Reserved bits read zero, ignore writes.
`timescale 1ns/1ps
`default_nettype none
`include "tsc_consts.svh"
module tsc_regs
  import tsc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire tsc_pkg::tsc_ps_req_type ps_req,
  output logic ps_rvalid,
  output logic [31:0] ps_rdata,
  input wire tsc_pkg::tsc_byte_type msg_in,
  output tsc_pkg::tsc_byte_type msg_out,
  output logic [23:0] reply_dest,
  input wire logic [31:0] otp_security_word,
  input wire logic otp_load,
  input wire logic [31:0] boot_state_in,
  input wire logic debug_mode,
  input wire tsc_pkg::tsc_dbg_evt_type dbg_evt,
  input wire logic [15:0] event_vector,
  input wire logic event_take,
  output logic [31:0] event_target,
  input wire logic all_threads_paused,
  input wire logic pll_clk_tick,
  input wire logic [15:0] clk_div_value,
  output logic tile_clk_divide,
  output logic rgmii_ports_enable,
  output logic [7:0] rgmii_tx_delay,
  output logic rgmii_tx_clk,
  output logic [31:0] security_flags
);
  import tsc_pkg::*;

  logic [31:0] ram_base_address_r;
  logic [31:0] vector_base_address_r;
  logic [31:0] tile_feature_control_r;
  logic [31:0] security_settings_r;
  logic [31:0] debug_read_thread_operand_r;
  logic [31:0] debug_read_reg_operand_r;
  logic [31:0] debug_irq_cause_r;
  logic ps_rvalid_r;
  logic [31:0] ps_rdata_r;
  logic [31:0] event_target_r;
  logic tile_clk_divide_r;
  logic [8:0] tx_cnt_r;
  logic tx_clk_r;
  logic [31:0] reply_word_r;
  logic [2:0] reply_cnt_r;
  logic [23:0] reply_dest_r;
  tsc_byte_type msg_out_r;
  tsc_acc_type acc;
  logic acc_write;
  logic [7:0] acc_reg;
  logic [31:0] acc_wdata;
  logic [31:0] acc_rdata;
  logic rx_done;
  logic rx_write;
  logic [23:0] rx_ret;
  logic [7:0] rx_reg;
  logic [31:0] rx_wdata;
  logic ps_hit;
  logic [1:0] hit_index;
  logic [31:0] cause_nxt;
  logic [8:0] tx_div;
  logic [8:0] tx_cnt_nxt;
  logic tx_clk_nxt;
  logic want_reply;

  // Byte collector for interconnect access messages.
  tsc_msg_rx u_rx
  (
    .clk_sys(clk_sys),
    .reset(reset),
    .rx_in(msg_in),
    .done(rx_done),
    .is_write(rx_write),
    .ret_dest(rx_ret),
    .reg_num(rx_reg),
    .wdata(rx_wdata)
  );

  // Lowest numbered breakpoint unit wins when several fire together.
  tsc_lowest_hit u_hit
  (
    .hits(dbg_evt.unit_hits),
    .index(hit_index)
  );

  // Local accesses must name the processor-status resource type in the low byte.
  assign ps_hit = ps_req.valid && (ps_req.res_id[7:0] == `TSC_RES_TYPE_PS); // R4

  // Local core has priority; a message completing in the same cycle is dropped, so requesters must avoid it.
  assign acc = ps_hit ? (ps_req.write ? TSC_ACC_WRITE : TSC_ACC_READ)
             : rx_done ? (rx_write ? TSC_ACC_WRITE : TSC_ACC_READ) : TSC_ACC_NONE;
  assign acc_write = (acc == TSC_ACC_WRITE);
  assign acc_reg = ps_hit ? ps_req.res_id[15:8] : rx_reg; // R4
  assign acc_wdata = ps_hit ? ps_req.wdata : rx_wdata;
  assign want_reply = rx_done && !ps_hit && (rx_ret[7:0] != `TSC_NO_REPLY_LOW); // R2 R1

  // Read multiplexer; reserved bits are held at zero by the write masks, and in boot state by a read mask.
  assign acc_rdata =
      (acc_reg == `TSC_REG_RAM_BASE) ? ram_base_address_r
    : (acc_reg == `TSC_REG_VEC_BASE) ? vector_base_address_r
    : (acc_reg == `TSC_REG_TILE_CTRL) ? tile_feature_control_r
    : (acc_reg == `TSC_REG_BOOT_STATE) ? (boot_state_in & 32'h00FF013F) // R12 R22
    : (acc_reg == `TSC_REG_SECURITY) ? security_settings_r
    : (acc_reg == `TSC_REG_DBG_THREAD) ? debug_read_thread_operand_r
    : (acc_reg == `TSC_REG_DBG_REGNUM) ? debug_read_reg_operand_r
    : (acc_reg == `TSC_REG_DBG_CAUSE) ? debug_irq_cause_r
    : 32'h00000000;

  // Hardware cause update; host causes carry no thread and no unit number.
  assign cause_nxt = {14'h0,
    ((dbg_evt.cause == `TSC_CAUSE_HOST) || (dbg_evt.cause == `TSC_CAUSE_DEBUG_CALL_INSTR)) ? 2'h0 : hit_index, // R19
    (dbg_evt.cause == `TSC_CAUSE_HOST) ? 8'h00 : dbg_evt.thread, // R20
    5'h00, dbg_evt.cause}; // R18

  // Plain writable registers; writes only land in their defined bits.
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      ram_base_address_r <= `TSC_RAM_BASE_RESET; // R6
      vector_base_address_r <= 32'h00000000;
      tile_feature_control_r <= 32'h00000000; // R8 R10
    end
    else if (acc_write && acc_reg == `TSC_REG_RAM_BASE)
      ram_base_address_r <= acc_wdata & `TSC_RAM_BASE_MASK; // R6 R22
    else if (acc_write && acc_reg == `TSC_REG_VEC_BASE)
      vector_base_address_r <= acc_wdata & `TSC_VEC_BASE_MASK; // R22
    else if (acc_write && acc_reg == `TSC_REG_TILE_CTRL)
      tile_feature_control_r <= acc_wdata & `TSC_TILE_CTRL_MASK; // R8 R9 R10 R11 R22
  end

  // Security copy: loaded from OTP, then writable only until the lock bit is set.
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      security_settings_r <= 32'h00000000;
    else if (otp_load)
      security_settings_r <= otp_security_word & `TSC_SECURITY_MASK; // R13
    else if (acc_write && acc_reg == `TSC_REG_SECURITY && !security_settings_r[`TSC_SEC_LOCK_BIT])
      security_settings_r <= acc_wdata & `TSC_SECURITY_MASK; // R14 R15 R16
  end

  // Debug operands accept writes only while the core is in debug mode.
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      debug_read_thread_operand_r <= 32'h00000000;
      debug_read_reg_operand_r <= 32'h00000000;
    end
    else if (acc_write && debug_mode && acc_reg == `TSC_REG_DBG_THREAD)
      debug_read_thread_operand_r <= acc_wdata & `TSC_DBG_THREAD_MASK; // R17
    else if (acc_write && debug_mode && acc_reg == `TSC_REG_DBG_REGNUM)
      debug_read_reg_operand_r <= acc_wdata & `TSC_DBG_REGNUM_MASK; // R17
  end

  // A fresh hardware cause wins over a software write in the same cycle.
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      debug_irq_cause_r <= 32'h00000000; // R18
    else if (dbg_evt.valid)
      debug_irq_cause_r <= cause_nxt;
    else if (acc_write && debug_mode && acc_reg == `TSC_REG_DBG_CAUSE)
      debug_irq_cause_r <= acc_wdata & `TSC_DBG_CAUSE_MASK;
  end

  // Local read answer one cycle after the request.
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      ps_rvalid_r <= 1'b0;
      ps_rdata_r <= 32'h00000000;
    end
    else
    begin
      ps_rvalid_r <= ps_hit && !ps_req.write;
      ps_rdata_r <= (ps_hit && !ps_req.write) ? acc_rdata : ps_rdata_r;
    end
  end

  // Event address: upper half from the vector base, lower from the resource.
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      event_target_r <= 32'h00000000;
    else if (event_take)
      event_target_r <= {vector_base_address_r[31:16], event_vector}; // R7
  end

  // Divider request; dynamic mode only divides while every active thread waits.
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      tile_clk_divide_r <= 1'b0;
    else
      tile_clk_divide_r <= tile_feature_control_r[`TSC_CTRL_DIV_EN_BIT]
        && (clk_div_value != 16'h0000) // R21
        && (!tile_feature_control_r[`TSC_CTRL_DYN_BIT] || all_threads_paused); // R11
  end

  // Transmit clock counter runs on PLL ticks; high at the top value, low at half.
  assign tx_div = tile_feature_control_r[17:9];
  assign tx_cnt_nxt = (tx_cnt_r >= tx_div) ? 9'h000 : tx_cnt_r + 9'h001; // R9
  assign tx_clk_nxt = (tx_cnt_r == tx_div) ? 1'b1 : (tx_cnt_r == (tx_div >> 1)) ? 1'b0 : tx_clk_r; // R9

  always_ff @(posedge clk_sys)
  begin
    if (reset || !tile_feature_control_r[`TSC_CTRL_RGMII_EN_BIT])
    begin
      tx_cnt_r <= 9'h000;
      tx_clk_r <= 1'b0;
    end
    else if (pll_clk_tick)
    begin
      tx_cnt_r <= tx_cnt_nxt;
      tx_clk_r <= tx_clk_nxt;
    end
  end

  // Reply sender: four data bytes, most significant first, to the named channel-end.
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      reply_cnt_r <= 3'h0;
      reply_word_r <= 32'h00000000;
      reply_dest_r <= 24'h000000;
      msg_out_r <= '0;
    end
    else if (want_reply && reply_cnt_r == 3'h0)
    begin
      reply_cnt_r <= 3'h4;
      reply_word_r <= rx_write ? 32'h00000000 : acc_rdata;
      reply_dest_r <= rx_ret; // R1
      msg_out_r <= '0;
    end
    else if (reply_cnt_r != 3'h0)
    begin
      reply_cnt_r <= reply_cnt_r - 3'h1;
      reply_word_r <= {reply_word_r[23:0], 8'h00};
      msg_out_r <= {1'b1, reply_cnt_r == 3'h1, reply_word_r[31:24]}; // R3
    end
    else
      msg_out_r <= '0;
  end

  // Every output leaves straight from a flip-flop.
  assign ps_rvalid = ps_rvalid_r;
  assign ps_rdata = ps_rdata_r;
  assign msg_out = msg_out_r;
  assign reply_dest = reply_dest_r;
  assign event_target = event_target_r;
  assign tile_clk_divide = tile_clk_divide_r;
  assign rgmii_ports_enable = tile_feature_control_r[`TSC_CTRL_RGMII_EN_BIT]; // R10
  assign rgmii_tx_delay = tile_feature_control_r[25:18]; // R8
  assign rgmii_tx_clk = tx_clk_r;
  assign security_flags = security_settings_r; // R15 R16
endmodule
`default_nettype wire

/* File: testbench/tsc_regs_sva.sv */
// Checker for the tile status register bank, bound to its top module.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module tsc_regs_sva
  import tsc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire tsc_pkg::tsc_ps_req_type ps_req,
  input wire logic ps_rvalid,
  input wire logic [31:0] ps_rdata,
  input wire tsc_pkg::tsc_byte_type msg_in,
  input wire tsc_pkg::tsc_byte_type msg_out,
  input wire logic [15:0] event_vector,
  input wire logic event_take,
  input wire logic [31:0] event_target,
  input wire logic rgmii_ports_enable,
  input wire logic [7:0] rgmii_tx_delay,
  input wire logic rgmii_tx_clk,
  input wire logic [31:0] security_flags
);
  // A local request counts only with the status type code in the low byte.
  wire typ_ok = ps_req.res_id[7:0] == 8'h0B;
  wire rd_go = ps_req.valid && !ps_req.write && typ_ok;
  wire [7:0] rd_reg = ps_req.res_id[15:8];
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  // Local reads answer one cycle later, and show the live register fields.
  chk_read_latency: assert property (rd_go |=> ps_rvalid)
    else $error("local read not answered");
  chk_bad_type: assert property (ps_req.valid && !typ_ok |=> !ps_rvalid)
    else $error("foreign type code answered");
  chk_ram_low: assert property (rd_go && rd_reg == 8'h00 |=> ps_rdata[1:0] == 2'h0)
    else $error("ram base low bits not zero");
  chk_boot_reserved: assert property (rd_go && rd_reg == 8'h03 |=> (ps_rdata & 32'hFF00FEC0) == 32'h0)
    else $error("boot state reserved bits set");
  chk_sec_copy: assert property (rd_go && rd_reg == 8'h05 |=> ps_rdata == $past(security_flags))
    else $error("security read differs from flags");
  chk_ctrl_fields: assert property (rd_go && rd_reg == 8'h02 |=>
    {ps_rdata[25:18], ps_rdata[8]} == $past({rgmii_tx_delay, rgmii_ports_enable}))
    else $error("control read differs from outputs");
  // Vector target carries the event vector in its low half.
  chk_vec_target: assert property (event_take |=> event_target[15:0] == $past(event_vector))
    else $error("event target low half wrong");
  // The transmit clock is held low while the interface is off.
  chk_tx_clk_hold: assert property (!rgmii_ports_enable |=> !rgmii_tx_clk)
    else $error("tx clock high while disabled");
  // Replies are four bytes, the last one marked, after a two cycle gap.
  chk_reply_shape: assert property ($rose(msg_out.valid) |->
    (msg_out.valid && !msg_out.last)[*3] ##1 (msg_out.valid && msg_out.last) ##1 !msg_out.valid)
    else $error("reply not four bytes");
  chk_reply_gap: assert property (msg_in.valid && msg_in.last |=> (!msg_out.valid)[*2])
    else $error("reply started too early");
endmodule
`default_nettype wire

/* File: testbench/tsc_req_model.sv */
// Interconnect requester that sends access messages and gathers replies.
// Assumes the bench calls send just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
`include "tsc_consts.svh"
module tsc_req_model
  import tsc_pkg::*;
(
  input wire logic clk_sys,
  output var tsc_pkg::tsc_byte_type msg_in,
  input wire tsc_pkg::tsc_byte_type msg_out
);
  logic [31:0] reply_word = 32'h0;
  int reply_bytes = 0;
  initial msg_in = '0;
  // Reply bytes shift in most significant first.
  always @(posedge clk_sys)
    if (msg_out.valid)
    begin
      reply_word <= {reply_word[23:0], msg_out.data};
      reply_bytes <= reply_bytes + 1;
    end
  // Each message names the return channel-end; idle data is inverted to stay untrusted.
  task automatic send(input logic [7:0] cmd, input logic [23:0] ret, input logic [7:0] rn, input logic [31:0] wd);
    logic [71:0] m;
    int n;
    m = {cmd, ret, rn, wd};
    n = (cmd == `TSC_MSG_WR) ? 9 : 5;
    for (int i = 0; i < n; i++)
    begin
      msg_in <= '{1'b1, i == n - 1, m[71 - 8 * i -: 8]};
      @(posedge clk_sys);
    end
    msg_in <= '{1'b0, 1'b0, ~m[71 - 8 * (n - 1) -: 8]};
  endtask
endmodule
`default_nettype wire

/* File: testbench/tb_top.sv */
// Self-checking bench for the tile status register bank.
// Assumes the requester model and the bound checker are compiled with it.
`timescale 1ns/1ps
`default_nettype none
`include "tsc_consts.svh"
module tb_top;
  import tsc_pkg::*;
  logic clk_sys, reset, otp_load, debug_mode, event_take, all_threads_paused, pll_clk_tick;
  logic ps_rvalid, tile_clk_divide, rgmii_ports_enable, rgmii_tx_clk;
  logic [31:0] ps_rdata, otp_security_word, boot_state_in, event_target, security_flags, rd, d;
  logic [23:0] reply_dest;
  logic [15:0] event_vector, clk_div_value;
  logic [7:0] rgmii_tx_delay, r, t;
  logic [3:0] h;
  tsc_ps_req_type ps_req;
  tsc_dbg_evt_type dbg_evt;
  tsc_byte_type msg_in, msg_out;
  int seed = 87;
  int num_errors = 0;
  int n_compared = 0;
  logic [7:0] regs [8] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h13, 8'h14, 8'h15, 8'h07};
  tsc_regs tsc_regs_inst (.clk_sys, .reset, .ps_req, .ps_rvalid, .ps_rdata, .msg_in, .msg_out,
    .reply_dest, .otp_security_word, .otp_load, .boot_state_in, .debug_mode, .dbg_evt,
    .event_vector, .event_take, .event_target, .all_threads_paused, .pll_clk_tick, .clk_div_value,
    .tile_clk_divide, .rgmii_ports_enable, .rgmii_tx_delay, .rgmii_tx_clk, .security_flags);
  tsc_req_model tsc_req_model_inst (.clk_sys, .msg_in, .msg_out);
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // PLL ticks arrive irregularly so the transmit divider sees uneven pacing.
  always @(posedge clk_sys)
    pll_clk_tick <= 1'($random(seed));
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  // One local access; a read is sampled at the falling edge after its answer.
  task automatic ps(input logic w, input logic [7:0] rn, input logic [31:0] wd, input logic [7:0] ty = 8'h0B);
    @(posedge clk_sys);
    ps_req <= '{1'b1, w, {rn, ty}, wd};
    @(posedge clk_sys);
    ps_req <= '{1'b0, 1'b0, 16'h0, ~wd};
    @(negedge clk_sys);
    if (!w) chk("rvalid", 32'(ps_rvalid), 32'(ty == 8'h0B));
    rd = ps_rdata;
  endtask
  task automatic rdchk(input string nm, input logic [7:0] rn, input logic [31:0] e);
    ps(1'b0, rn, 32'h0);
    chk(nm, rd, e);
  endtask
  function automatic logic [31:0] expv(logic [7:0] rn, logic [31:0] wd);
    case (rn)
      8'h00: return wd & `TSC_RAM_BASE_MASK;
      8'h01: return wd & `TSC_VEC_BASE_MASK;
      8'h02: return wd & `TSC_TILE_CTRL_MASK;
      8'h03: return boot_state_in & 32'h00FF013F;
      8'h13: return wd & `TSC_DBG_THREAD_MASK;
      8'h14: return wd & `TSC_DBG_REGNUM_MASK;
      8'h15: return wd & `TSC_DBG_CAUSE_MASK;
      default: return 32'h0;
    endcase
  endfunction
  // Hosts and debug calls name no unit; the host names no thread either.
  function automatic logic [31:0] cause_exp(logic [2:0] c, logic [7:0] th, logic [3:0] hit);
    logic [1:0] u;
    u = hit[0] ? 2'h0 : hit[1] ? 2'h1 : hit[2] ? 2'h2 : hit[3] ? 2'h3 : 2'h0;
    if (c < 3'h3) u = 2'h0;
    if (c == `TSC_CAUSE_HOST) th = 8'h0;
    return {14'h0, u, th, 5'h0, c};
  endfunction
  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // The whole run needs a few hundred cycles; this limit cuts a hang short.
  initial
  begin
    #1000000;
    num_errors++;
    summarize();
  end
  initial
  begin
    {otp_load, debug_mode, event_take, all_threads_paused} = 4'h0;
    ps_req = '0;
    dbg_evt = '0;
    otp_security_word = 32'h0;
    boot_state_in = 32'h0;
    event_vector = 16'h0;
    clk_div_value = 16'h0;
    reset = 1'b1;
    repeat (8) @(posedge clk_sys);
    reset <= 1'b0;
    rdchk("ram_base", 8'h00, `TSC_RAM_BASE_RESET);
    rdchk("cause", 8'h15, 32'h0);
    rdchk("ctrl", 8'h02, 32'h0);
    @(posedge clk_sys);
    debug_mode <= 1'b1;
    boot_state_in <= $random(seed);
    // Random writes with readback; read-only and unmapped places keep their value.
    for (int i = 0; i < 48; i++)
    begin
      r = regs[i % 8];
      d = $random(seed);
      ps(1'b1, r, d);
      if (r == 8'h02) chk("ctrl_out", 32'({rgmii_tx_delay, rgmii_ports_enable}), 32'({d[25:18], d[8]}));
      rdchk("readback", r, expv(r, d));
    end
    ps(1'b1, 8'h13, 32'h0000005A);
    @(posedge clk_sys);
    debug_mode <= 1'b0;
    ps(1'b1, 8'h13, 32'h000000FF);
    rdchk("thread_op", 8'h13, 32'h0000005A);
    ps(1'b1, 8'h00, 32'h12345678, 8'h0C);
    ps(1'b0, 8'h00, 32'h0, 8'h0C);
    ps(1'b1, 8'h00, 32'h00A00001);
    rdchk("ram_base", 8'h00, 32'h00A00000);
    // Security copy, then a lock that refuses writes until the next load.
    @(posedge clk_sys);
    otp_security_word <= 32'h7FFFFFFF;
    otp_load <= 1'b1;
    @(posedge clk_sys);
    otp_load <= 1'b0;
    rdchk("security", 8'h05, `TSC_SECURITY_MASK & 32'h7FFFFFFF);
    ps(1'b1, 8'h05, 32'h80000011);
    chk("sec_flags", security_flags, 32'h80000011);
    ps(1'b1, 8'h05, 32'h00000001);
    rdchk("security", 8'h05, 32'h80000011);
    @(posedge clk_sys);
    otp_security_word <= 32'h00001000;
    otp_load <= 1'b1;
    @(posedge clk_sys);
    otp_load <= 1'b0;
    rdchk("security", 8'h05, 32'h00001000);
    // Every debug cause, with random thread and unit hits.
    for (int c = 1; c < 6; c++)
    begin
      h = 4'($random(seed));
      t = 8'($random(seed));
      @(posedge clk_sys);
      dbg_evt <= '{1'b1, 3'(c), t, h};
      @(posedge clk_sys);
      dbg_evt.valid <= 1'b0;
      rdchk("cause", 8'h15, cause_exp(3'(c), t, h));
    end
    d = $random(seed);
    ps(1'b1, 8'h01, d);
    @(posedge clk_sys);
    event_vector <= 16'($random(seed));
    event_take <= 1'b1;
    @(posedge clk_sys);
    event_take <= 1'b0;
    @(negedge clk_sys);
    chk("target", event_target, {d[31:18], 2'h0, event_vector});
    // Divider modes: enable bit 4, dynamic bit 5, with and without paused threads.
    clk_div_value <= 16'h0003;
    for (int m = 0; m < 8; m++)
    begin
      ps(1'b1, 8'h02, {26'h0, m[2:1], 4'h0});
      @(posedge clk_sys);
      all_threads_paused <= m[0];
      repeat (3) @(posedge clk_sys);
      @(negedge clk_sys);
      chk("divide", 32'(tile_clk_divide), 32'(m[1] && (!m[2] || m[0])));
    end
    // Remote write without reply, remote read, then a write that asks for a reply.
    d = $random(seed);
    @(posedge clk_sys);
    tsc_req_model_inst.send(`TSC_MSG_WR, 24'hABCDFF, 8'h00, d);
    repeat (8) @(posedge clk_sys);
    chk("no_reply", 32'(tsc_req_model_inst.reply_bytes), 32'h0);
    rdchk("ram_base", 8'h00, d & `TSC_RAM_BASE_MASK);
    @(posedge clk_sys);
    tsc_req_model_inst.send(`TSC_MSG_RD, 24'h123456, 8'h00, 32'h0);
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys);
    chk("reply", tsc_req_model_inst.reply_word, d & `TSC_RAM_BASE_MASK);
    chk("reply_dest", 32'(reply_dest), 32'h00123456);
    @(posedge clk_sys);
    tsc_req_model_inst.send(`TSC_MSG_WR, 24'h123401, 8'h01, 32'hFFFC0000);
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys);
    chk("wr_reply", tsc_req_model_inst.reply_word, 32'h0);
    chk("reply_count", 32'(tsc_req_model_inst.reply_bytes), 32'h8);
    rdchk("vec_base", 8'h01, 32'hFFFC0000);
    summarize();
  end
endmodule
bind tsc_regs tsc_regs_sva tsc_regs_sva_inst (.clk_sys, .reset, .ps_req, .ps_rvalid, .ps_rdata,
  .msg_in, .msg_out, .event_vector, .event_take, .event_target, .rgmii_ports_enable,
  .rgmii_tx_delay, .rgmii_tx_clk, .security_flags);
`default_nettype wire
